/* logic/watch_timer_regs.svh */
// Summary of operation
// - reset loads the mode control register with 00H: stopped, divided main clock.
// - register takes whole-byte writes, and single-bit writes to bits 7..4, 1 and 0 without touching other bits.
// - bit 7 picks the timer clock: main clock over 128, or subsystem clock.
// - bits 6..4 pick interval 2^4..2^9 timer clocks; other codes are prohibited.
// - bit 1 low stops and clears the 5-bit counter; high lets it count.
// - bit 0 low stops everything, clearing prescaler and counter; high enables.
// - with bits 0 and 1 set, watch interrupt fires every half second.
// - clearing bit 1 alone restarts the counter but leaves the prescaler running.
// - interval interrupt fires each time the selected prescaler interval elapses.
// - watch and interval functions run together on the same interrupt.
// - interval interrupt uses the same watch interrupt line.
`ifndef WATCH_TIMER_REGS_SVH
`define WATCH_TIMER_REGS_SVH
`define WT_ADDR        16'hFF4A
`define WT_RESET       8'h00
`define WT_WRITE_MASK  8'hF3
`define WT_DIV_W       7
`define WT_PRE_W       9
`define WT_CNT_W       5
`define WT_INTV_BASE   4
`define WT_INTV_MAX    3'h5
`define WT_BIT_CLKSEL  3'h7
`define WT_BIT_RSV_HI  3'h3
`define WT_BIT_RSV_LO  3'h2
`endif

/* logic/watch_timer_pkg.sv */
`default_nettype none
package watch_timer_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic        wrByte;
        logic        wrBit;
        logic [2:0]  bitSel;
        logic        bitVal;
        logic [7:0]  wrData;
        logic        rdEn;
    } cpu_req_t;

    typedef struct packed {
        logic       clockSourceSel;
        logic [2:0] intervalSel;
        logic [1:0] reserved;
        logic       counterRun;
        logic       timerEnable;
    } watch_mode_ctrl_t;
endpackage : watch_timer_pkg
`default_nettype wire

/* logic/watch_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "watch_timer_regs.svh"
module watch_interval_timer #(
    parameter int DIV_W = `WT_DIV_W,
    parameter int PRE_W = `WT_PRE_W,
    parameter int CNT_W = `WT_CNT_W
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire watch_timer_pkg::cpu_req_t cpuReq,
    input  wire logic                     subClk,
    output var  logic [7:0]               rdData,
    output var  logic                     watchIrq
);
    watch_timer_pkg::watch_mode_ctrl_t watchModeCtrl;
    logic [DIV_W-1:0] divCnt;
    logic [PRE_W-1:0] prescaler;
    logic [CNT_W-1:0] watchCnt;
    logic             subClkPrev;

    // register access decode
    wire        addrHit   = (cpuReq.addr == `WT_ADDR);
    wire        byteWr    = addrHit && cpuReq.wrByte;
    wire        bitWr     = addrHit && cpuReq.wrBit && !cpuReq.wrByte;
    wire        bitWrOk   = bitWr && (cpuReq.bitSel != `WT_BIT_RSV_HI)
                                  && (cpuReq.bitSel != `WT_BIT_RSV_LO);
    wire [7:0]  modeBits  = watchModeCtrl;
    wire [7:0]  bitMask   = 8'h01 << cpuReq.bitSel;
    wire [7:0]  bitMerged = cpuReq.bitVal ? (modeBits | bitMask) : (modeBits & ~bitMask);
    wire [7:0]  next_mode = byteWr  ? (cpuReq.wrData & `WT_WRITE_MASK) :
                            bitWrOk ? bitMerged : modeBits;

    wire timerEn  = watchModeCtrl.timerEnable;
    wire cntRun   = watchModeCtrl.counterRun;

    // timer clock source
    wire divTick  = (divCnt == {DIV_W{1'b1}});
    wire subTick  = subClk && !subClkPrev;
    wire tick     = watchModeCtrl.clockSourceSel ? subTick : divTick;

    // interval selection mask, prohibited codes treated as longest interval
    wire [2:0] intvCode = (watchModeCtrl.intervalSel > `WT_INTV_MAX) ?
                          `WT_INTV_MAX : watchModeCtrl.intervalSel;
    wire [3:0] intvLen  = 4'(`WT_INTV_BASE) + {1'h0, intvCode};
    logic [PRE_W-1:0] intvMask;
    genvar gi;
    generate
        for (gi = 0; gi < PRE_W; gi++) begin : g_mask
            assign intvMask[gi] = (4'(gi) < intvLen);
        end
    endgenerate

    wire preFull       = &prescaler;
    wire intervalEvent = timerEn && tick && (&(prescaler | ~intvMask));
    wire cntAdvance    = timerEn && cntRun && tick && preFull;
    wire watchEvent    = cntAdvance && (&watchCnt);
    wire [PRE_W-1:0] next_prescaler = !timerEn ? '0 :
                                      tick ? PRE_W'(prescaler + 1'b1) : prescaler;
    wire [CNT_W-1:0] next_watchCnt  = (!timerEn || !cntRun) ? '0 :
                                      cntAdvance ? CNT_W'(watchCnt + 1'b1) : watchCnt;
    wire [7:0]  next_rdData = (addrHit && cpuReq.rdEn) ? modeBits : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            watchModeCtrl <= `WT_RESET;
        end else begin
            watchModeCtrl <= next_mode;
        end
    end

    // main clock divided by 128
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divCnt     <= '0;
            subClkPrev <= 1'b0;
        end else begin
            divCnt     <= DIV_W'(divCnt + 1'b1);
            subClkPrev <= subClk;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prescaler <= '0;
            watchCnt  <= '0;
        end else begin
            prescaler <= next_prescaler;
            watchCnt  <= next_watchCnt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            watchIrq <= 1'b0;
            rdData   <= 8'h00;
        end else begin
            watchIrq <= watchEvent || intervalEvent;
            rdData   <= next_rdData;
        end
    end

    a_reset_value_zero: assert property (@(posedge ref_clk)
        !rst_n |=> watchModeCtrl == `WT_RESET)
        else $error("mode register not cleared by reset");

    a_byte_write_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (addrHit && cpuReq.wrByte) |=> modeBits == ($past(cpuReq.wrData) & `WT_WRITE_MASK))
        else $error("byte write did not load mode register");

    a_bit_write_isolated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bitWrOk
        |=> (modeBits & $past(bitMask)) == ($past(cpuReq.bitVal) ? $past(bitMask) : 8'h00)
        && ((modeBits ^ $past(modeBits)) & ~$past(bitMask)) == 8'h00)
        else $error("bit write disturbed other bits");

    a_reserved_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        watchModeCtrl.reserved == 2'h0)
        else $error("reserved bits not zero");

    a_clock_source_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!watchModeCtrl.clockSourceSel && timerEn && !divTick && !byteWr && !bitWr)
        |=> prescaler == $past(prescaler))
        else $error("prescaler moved without divided clock tick");

    a_disable_clears_all: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !timerEn |=> prescaler == '0 && watchCnt == '0)
        else $error("disable did not clear prescaler and counter");

    a_counter_stop_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && !cntRun) |=> watchCnt == '0)
        else $error("counter not cleared while stopped");

    a_prescaler_kept_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && !cntRun && !tick) |=> prescaler == $past(prescaler))
        else $error("prescaler cleared by counter stop");

    a_watch_overflow_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && cntRun && tick && preFull && watchCnt == {CNT_W{1'b1}})
        |=> watchIrq && watchCnt == '0)
        else $error("watch overflow did not raise interrupt");

    a_interval_irq_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && tick && (&(prescaler | ~intvMask))) |=> watchIrq)
        else $error("interval elapsed without interrupt");

    a_irq_needs_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        watchIrq |-> $past(timerEn) && $past(tick))
        else $error("interrupt without enabled tick");

    // readback and write-path checks
    a_read_data_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (addrHit && cpuReq.rdEn) |=> rdData == $past(modeBits))
        else $error("read did not return mode register");

    a_read_miss_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(addrHit && cpuReq.rdEn) |=> rdData == 8'h00)
        else $error("read data not zero outside a read");

    a_reserved_bit_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bitWr && (cpuReq.bitSel == `WT_BIT_RSV_HI || cpuReq.bitSel == `WT_BIT_RSV_LO))
        |=> modeBits == $past(modeBits))
        else $error("bit write to reserved bit changed register");

    a_no_write_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!byteWr && !bitWr) |=> modeBits == $past(modeBits))
        else $error("mode register changed without a write");

    a_reset_outputs_low: assert property (@(posedge ref_clk)
        !rst_n |=> !watchIrq && rdData == 8'h00)
        else $error("outputs not cleared by reset");

    // timer-path checks
    a_divider_wraps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        divTick |=> divCnt == '0)
        else $error("divider did not wrap after tick");

    a_divided_tick_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!watchModeCtrl.clockSourceSel && timerEn && divTick)
        |=> prescaler == PRE_W'($past(prescaler) + 1'h1))
        else $error("divided clock tick did not step prescaler");

    a_sub_clock_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (watchModeCtrl.clockSourceSel && timerEn && !subTick)
        |=> prescaler == $past(prescaler))
        else $error("prescaler moved without subsystem clock edge");

    a_prescaler_counts: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && tick) |=> prescaler == PRE_W'($past(prescaler) + 1'h1))
        else $error("prescaler missed a tick");

    a_interval_min_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
        intervalEvent |-> &prescaler[`WT_INTV_BASE-1:0])
        else $error("interval shorter than the shortest setting");

    a_interval_code_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (intervalEvent && watchModeCtrl.intervalSel == `WT_INTV_MAX) |-> preFull)
        else $error("longest interval fired early");

    a_counter_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && cntRun && tick && preFull && watchCnt != {CNT_W{1'h1}})
        |=> watchCnt == CNT_W'($past(watchCnt) + 1'h1))
        else $error("counter did not advance on prescaler wrap");

    a_counter_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && cntRun && !(tick && preFull)) |=> watchCnt == $past(watchCnt))
        else $error("counter moved without prescaler wrap");

    a_disabled_no_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !timerEn |=> !watchIrq)
        else $error("interrupt while timer disabled");

    a_enable_starts_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(timerEn) |-> prescaler == '0)
        else $error("prescaler not zero at enable");

    a_counter_restart_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(cntRun) |-> watchCnt == '0)
        else $error("counter not zero at restart");

    a_watch_merge_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (timerEn && cntRun && tick && preFull) |=> watchIrq)
        else $error("counter step without interrupt pulse");

endmodule : watch_interval_timer
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [7:0] wr; logic [7:0] exp;} row_t;
    logic                      ref_clk;
    logic                      rst_n;
    logic                      subClk;
    watch_timer_pkg::cpu_req_t cpuReq;
    logic [7:0]                rdData;
    logic                      watchIrq;
    int                        fails;
    int                        testsRun;
    int                        pulses;
    row_t                      rows [4];

    watch_interval_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .cpuReq(cpuReq),
        .subClk(subClk), .rdData(rdData), .watchIrq(watchIrq));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) if (watchIrq === 1'b1) pulses = pulses + 1;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrB(input logic [15:0] a, input logic [7:0] d);
        cpuReq.addr = a;
        cpuReq.wrData = d;
        cpuReq.wrByte = 1'h1;
        @(negedge ref_clk);
        cpuReq.wrByte = 1'h0;
        @(negedge ref_clk);
    endtask : wrB

    task automatic wrBit(input logic [2:0] b, input logic v);
        cpuReq.addr = 16'hFF4A;
        cpuReq.bitSel = b;
        cpuReq.bitVal = v;
        cpuReq.wrBit = 1'h1;
        @(negedge ref_clk);
        cpuReq.wrBit = 1'h0;
        @(negedge ref_clk);
    endtask : wrBit

    // idle cycle after each read so back-to-back reads never retoggle the strobe
    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        cpuReq.addr = a;
        cpuReq.rdEn = 1'h1;
        @(negedge ref_clk);
        cpuReq.rdEn = 1'h0;
        chk(rdData, exp);
        @(negedge ref_clk);
    endtask : rdChk

    // one timer tick is a rising edge of the subsystem clock
    task automatic ticks(input int n);
        repeat (n) begin
            subClk = 1'b1;
            @(negedge ref_clk);
            subClk = 1'b0;
            @(negedge ref_clk);
        end
        repeat (2) @(negedge ref_clk);
    endtask : ticks

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        summarize();
    end

    initial begin
        cpuReq = '0;
        subClk = 1'b0;
        rst_n = 1'b0;
        fails = 0;
        testsRun = 0;
        pulses = 0;
        rows = '{'{8'hDF, 8'hD3}, '{8'h0C, 8'h00}, '{8'hA5, 8'hA1}, '{8'h5E, 8'h52}};
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        rdChk(16'hFF4A, 8'h00);
        foreach (rows[i]) begin
            wrB(16'hFF4A, rows[i].wr);
            rdChk(16'hFF4A, rows[i].exp);
        end
        wrB(16'hFF4B, 8'hFF);
        rdChk(16'hFF4B, 8'h00);
        rdChk(16'hFF4A, 8'h52);
        wrBit(3'h7, 1'b1);
        wrBit(3'h3, 1'b1);
        wrBit(3'h4, 1'b0);
        rdChk(16'hFF4A, 8'hC2);
        rst_n = 1'b0;
        @(negedge ref_clk);
        rst_n = 1'b1;
        rdChk(16'hFF4A, 8'h00);
        for (int c = 0; c < 6; c++) begin
            wrB(16'hFF4A, 8'h00);
            wrB(16'hFF4A, {1'b1, c[2:0], 4'h1});
            pulses = 0;
            ticks(2 << (4 + c));
            chk(8'(pulses), 8'h02);
        end
        wrB(16'hFF4A, 8'h01);
        pulses = 0;
        repeat (1900) @(negedge ref_clk);
        chk(8'(pulses), 8'h00);
        repeat (2300) @(negedge ref_clk);
        chk(8'(pulses), 8'h02);
        wrB(16'hFF4A, 8'h00);
        wrB(16'hFF4A, 8'h81);
        ticks(8);
        wrB(16'hFF4A, 8'h80);
        pulses = 0;
        ticks(4);
        chk(8'(pulses), 8'h00);
        wrB(16'hFF4A, 8'h81);
        ticks(15);
        chk(8'(pulses), 8'h00);
        ticks(1);
        chk(8'(pulses), 8'h01);
        wrB(16'hFF4A, 8'h00);
        wrB(16'hFF4A, 8'h83);
        ticks(8);
        wrB(16'hFF4A, 8'h81);
        pulses = 0;
        ticks(8);
        chk(8'(pulses), 8'h01);
        wrB(16'hFF4A, 8'h00);
        wrB(16'hFF4A, 8'hD3);
        pulses = 0;
        ticks(16384);
        // watch overflow lands on an interval pulse: 32, not 33
        chk(8'(pulses), 8'h20);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
